// ==== verilog/pmr_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module pmr_host
  import pmr_pkg::*;
#(
  parameter int WU_CYC   = pmr_pkg::WU_SETTLE_CYC,
  parameter int HALF_CYC = pmr_pkg::SCLK_HALF_CYC
) (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq,
  pmr_link_if.host         link
);
  import pmr_pkg::*;

  localparam int SW = $clog2(WU_CYC + 1);

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  logic              ack_q;
  logic [31:0]       rd_q;
  logic [7:0]        tx_q;
  logic [7:0]        rx_q;
  logic [7:0]        sh_q;
  logic [IRQ_W-1:0]  ist_q;
  logic [IRQ_W-1:0]  imask_q;
  logic [IRQ_W-1:0]  iset;
  pmr_hstate_t       st_q;
  logic [7:0]        div_q;
  logic [3:0]        edge_q;
  logic              sclk_q;
  logic              cs_q;
  logic [SW-1:0]     settle_q;
  logic [1:0]        miso_m;

  wire req   = wb_cyc_i & wb_stb_i;
  wire wr    = req & wb_we_i & ack_q & wb_sel_i[0];
  wire busy  = (st_q != H_IDLE);
  wire wait_ = (settle_q != '0);
  wire start = wr & (wb_adr_i == WB_TX) & ~busy & ~wait_; // see RQ4
  wire tick  = (div_q == 8'h00);
  wire [31:0] rdata =
    (wb_adr_i == WB_TX)       ? {24'h000000, tx_q} :
    (wb_adr_i == WB_STAT)     ? {16'h0000, rx_q, 6'h00, wait_, busy} :
    (wb_adr_i == WB_IRQ_STAT) ? {30'h00000000, ist_q} :
    (wb_adr_i == WB_IRQ_MASK) ? {30'h00000000, imask_q} : 32'h00000000;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ack_q <= 1'b0;
      rd_q  <= 32'h00000000;
    end else begin
      ack_q <= req & ~ack_q;
      rd_q  <= rdata;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rd_q;

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  wire frame_done = (st_q == H_TAIL) & tick;
  assign iset = {frame_done & rx_q[RSP_TER_BIT], frame_done};
  wire [IRQ_W-1:0] iclr =
    (wr && wb_adr_i == WB_IRQ_STAT) ? wb_dat_i[IRQ_W-1:0] : '0;

  // A new event outranks a clear written in the same cycle.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ist_q   <= '0;
      imask_q <= '0;
    end else begin
      ist_q <= (ist_q & ~iclr) | iset;
      if (wr && wb_adr_i == WB_IRQ_MASK) begin
        imask_q <= wb_dat_i[IRQ_W-1:0];
      end
    end
  end

  assign irq = |(ist_q & imask_q);

  // ----------------------------------------------------------------
  // Link engine
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      miso_m <= 2'h3;
    end else begin
      miso_m <= {miso_m[0], link.miso};
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_q   <= H_IDLE;
      div_q  <= 8'h00;
      edge_q <= 4'h0;
      sclk_q <= 1'b0;
      cs_q   <= 1'b1;
      sh_q   <= 8'h00;
      tx_q   <= 8'h00;
      rx_q   <= 8'h00;
    end else begin
      div_q <= (tick || !busy) ? 8'(HALF_CYC - 1) : div_q - 8'h01;
      case (st_q)
        H_IDLE: begin
          if (start) begin
            tx_q   <= wb_dat_i[7:0];
            sh_q   <= wb_dat_i[7:0];
            cs_q   <= 1'b0;
            edge_q <= 4'h0;
            st_q   <= H_SHIFT;
          end
        end
        H_SHIFT: begin
          if (tick) begin
            edge_q <= edge_q + 4'h1;
            sclk_q <= ~edge_q[0];
            if (!edge_q[0]) begin
              rx_q <= {rx_q[6:0], miso_m[1]};
            end else begin
              sh_q <= {sh_q[6:0], 1'b0};
            end
            if (edge_q == 4'hF) begin
              st_q <= H_TAIL;
            end
          end
        end
        H_TAIL: begin
          if (tick) begin
            cs_q <= 1'b1;
            st_q <= H_GAP;
          end
        end
        H_GAP: begin
          if (tick) begin
            st_q <= H_IDLE;
          end
        end
        default: begin
          st_q <= H_IDLE;
        end
      endcase
    end
  end

  // Any wake frame blocks further frames for the full settle time.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      settle_q <= '0;
    end else if (frame_done && pmr_cmd_bit(tx_q, CMD_WAKE_BIT)) begin
      settle_q <= SW'(WU_CYC); // see RQ4
    end else if (wait_) begin
      settle_q <= settle_q - SW'(1);
    end
  end

  assign link.cs_n = cs_q;
  assign link.sclk = sclk_q;
  assign link.mosi = sh_q[7];

endmodule
`default_nettype wire

// ==== include/pmr_pkg.sv ====
`default_nettype none
package pmr_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ        = 125;
  localparam int CLK_NS         = 8;
  localparam int SCLK_PERIOD_NS = 160;
  localparam int SCLK_HALF_CYC  = SCLK_PERIOD_NS / (2 * CLK_NS);
  localparam int WU_SETTLE_US   = 100;
  localparam int WU_SETTLE_CYC  = WU_SETTLE_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int         FRM_W         = 8;
  localparam int         CHAN_N        = 6;
  localparam logic [1:0] OP_CMD        = 2'h3;
  localparam logic [1:0] OP_WRITE      = 2'h2;
  localparam int         CMD_WAKE_BIT  = 0;
  localparam int         STANDBY_REQUEST_BIT_BIT   = 1;
  localparam int         CMD_RST_BIT   = 2;
  localparam int         RSP_TER_BIT   = 7;
  localparam int         RSP_SLEEP_BIT = 6;
  localparam logic [5:0] CHAN_RST      = 6'h00;

  // ----------------------------------------------------------------
  // Controller registers
  // ----------------------------------------------------------------
  localparam logic [3:0] WB_TX       = 4'h0;
  localparam logic [3:0] WB_STAT     = 4'h4;
  localparam logic [3:0] WB_IRQ_STAT = 4'h8;
  localparam logic [3:0] WB_IRQ_MASK = 4'hC;
  localparam int         STAT_BUSY   = 0;
  localparam int         STAT_SETTLE = 1;
  localparam int         STAT_RX_LSB = 8;
  localparam int         IRQ_DONE    = 0;
  localparam int         IRQ_TER     = 1;
  localparam int         IRQ_W       = 2;

  typedef enum logic [3:0] {
    H_IDLE  = 4'h1,
    H_SHIFT = 4'h2,
    H_TAIL  = 4'h4,
    H_GAP   = 4'h8
  } pmr_hstate_t;

  function automatic logic pmr_cmd_bit(input logic [7:0] f, input int b);
    return (f[7:6] == OP_CMD) && f[b];
  endfunction

endpackage
`default_nettype wire

// ==== include/pmr_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface pmr_link_if;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic so;
  logic so_oe;
  logic miso;

  // The line idles high when the device does not drive it.
  assign miso = so_oe ? so : 1'b1;

  modport dev (input cs_n, input sclk, input mosi, output so, output so_oe);
  modport host (output cs_n, output sclk, output mosi, input miso);
endinterface
`default_nettype wire

// ==== verilog/pmr_dev.sv ====
// How it works
// RQ1: Power-up reset clears registers, enters sleep.
// RQ2: Wake command bit moves sleep to operation.
// RQ3: Standby command bit returns to sleep.
// RQ4: Host waits settle time after wake.
// RQ5: Frames during settle time are discarded.
// RQ6: Shift path runs on logic supply alone.
// RQ7: Sleep mode also clears register bank.
// RQ8: Low battery supply raises under-voltage reset.
// RQ9: Any reset drops channels, loads defaults.
// RQ10: After reset, error flag set, sleep.
// RQ11: Under-voltage read returns frame with flag.
// RQ12: Release only when both supplies good.
// RQ13: Soft reset bit clears all registers.
// RQ14: Counter times settle, then frames accepted.
`timescale 1ns/1ps
`default_nettype none
module pmr_dev
  import pmr_pkg::*;
#(
  parameter int WU_CYC = pmr_pkg::WU_SETTLE_CYC
) (
  input  wire logic                     clock,
  input  wire logic                     rstn,
  input  wire logic                     logic_ok,
  input  wire logic                     batt_ok,
  pmr_link_if.dev                       link,
  output logic [pmr_pkg::CHAN_N-1:0]    chan_out,
  output logic                          sleep_mode,
  output logic                          uv_reset,
  output logic                          frame_error
);
  import pmr_pkg::*;

  localparam int SW = $clog2(WU_CYC + 1);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] cs_m;
  logic [1:0] sck_m;
  logic [1:0] si_m;
  logic [1:0] lok_m;
  logic [1:0] bok_m;
  logic       cs_d_q;
  logic       sck_d_q;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cs_m  <= 2'h3;
      sck_m <= 2'h0;
      si_m  <= 2'h0;
      lok_m <= 2'h0;
      bok_m <= 2'h0;
    end else begin
      cs_m  <= {cs_m[0], link.cs_n};
      sck_m <= {sck_m[0], link.sclk};
      si_m  <= {si_m[0], link.mosi};
      lok_m <= {lok_m[0], logic_ok};
      bok_m <= {bok_m[0], batt_ok};
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cs_d_q  <= 1'b1;
      sck_d_q <= 1'b0;
    end else begin
      cs_d_q  <= cs_m[1];
      sck_d_q <= sck_m[1];
    end
  end

  // ----------------------------------------------------------------
  // Supply supervision
  // ----------------------------------------------------------------
  wire vdd_ok   = lok_m[1];
  wire uv       = ~(lok_m[1] & bok_m[1]); // see RQ8 see RQ12
  wire cs_act   = ~cs_m[1];
  wire cs_fall  = cs_d_q & ~cs_m[1];
  wire cs_rise  = ~cs_d_q & cs_m[1];
  wire sck_rise = ~sck_d_q & sck_m[1] & cs_act;
  wire sck_fall = sck_d_q & ~sck_m[1] & cs_act;

  // ----------------------------------------------------------------
  // Shift register
  // ----------------------------------------------------------------
  // The shifter depends only on the logic supply, so a daisy chain
  // keeps forwarding bits while the battery supply is missing.
  logic [FRM_W-1:0] sr_q;
  logic [2:0]       cnt_q;
  logic             any_q;
  logic             si_lat_q;
  logic             sleep_q;
  logic             ter_q;
  logic [CHAN_N-1:0] chan_q;
  logic [SW-1:0]    settle_q;

  wire [FRM_W-1:0] rsp = {ter_q, sleep_q, chan_q}; // see RQ11

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sr_q     <= 8'h00;
      cnt_q    <= 3'h0;
      any_q    <= 1'b0;
      si_lat_q <= 1'b0;
    end else if (!vdd_ok) begin // see RQ6
      sr_q     <= 8'h00;
      cnt_q    <= 3'h0;
      any_q    <= 1'b0;
      si_lat_q <= 1'b0;
    end else if (cs_fall) begin
      sr_q     <= rsp;
      cnt_q    <= 3'h0;
      any_q    <= 1'b0;
    end else begin
      if (sck_rise) begin
        si_lat_q <= si_m[1];
      end
      if (sck_fall) begin
        sr_q  <= {sr_q[FRM_W-2:0], si_lat_q}; // see RQ6
        cnt_q <= cnt_q + 3'h1;
        any_q <= 1'b1;
      end
    end
  end

  assign link.so    = sr_q[FRM_W-1];
  assign link.so_oe = cs_act & vdd_ok; // see RQ11

  // ----------------------------------------------------------------
  // Frame decode
  // ----------------------------------------------------------------
  wire settle_busy = (settle_q != '0);
  wire frame_end   = cs_rise & vdd_ok;
  wire frame_len   = any_q & (cnt_q == 3'h0);
  wire frame_ok    = frame_end & frame_len & ~settle_busy; // see RQ5 see RQ14
  wire frame_bad   = frame_end & ~frame_len & ~settle_busy;
  wire cmd_wake    = frame_ok & pmr_cmd_bit(sr_q, CMD_WAKE_BIT);
  wire standby_request_bit     = frame_ok & pmr_cmd_bit(sr_q, STANDBY_REQUEST_BIT_BIT);
  wire cmd_rst     = frame_ok & pmr_cmd_bit(sr_q, CMD_RST_BIT);
  wire cmd_wr      = frame_ok & (sr_q[7:6] == OP_WRITE);
  wire any_rst     = uv | cmd_rst; // see RQ13
  wire go_sleep    = any_rst | standby_request_bit;

  // ----------------------------------------------------------------
  // Power mode
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sleep_q <= 1'b1; // see RQ1
    end else if (go_sleep) begin
      sleep_q <= 1'b1; // see RQ3 see RQ10
    end else if (cmd_wake) begin
      sleep_q <= 1'b0; // see RQ2
    end
  end

  // The settle timer only runs when a wake really changes the mode.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      settle_q <= '0;
    end else if (go_sleep) begin
      settle_q <= '0;
    end else if (cmd_wake && sleep_q) begin
      settle_q <= SW'(WU_CYC); // see RQ14
    end else if (settle_busy) begin
      settle_q <= settle_q - SW'(1);
    end
  end

  // ----------------------------------------------------------------
  // Register bank
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      chan_q <= CHAN_RST; // see RQ1
    end else if (go_sleep || sleep_q) begin
      chan_q <= CHAN_RST; // see RQ7 see RQ9 see RQ13
    end else if (cmd_wr) begin
      chan_q <= sr_q[CHAN_N-1:0];
    end
  end

  // The flag is cleared once a clean frame has carried it out; a reset
  // in the same cycle wins, so the event is never lost.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ter_q <= 1'b1; // see RQ10
    end else if (any_rst || frame_bad) begin
      ter_q <= 1'b1; // see RQ10
    end else if (frame_ok) begin
      ter_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign chan_out    = chan_q; // see RQ9
  assign sleep_mode  = sleep_q;
  assign uv_reset    = uv;
  assign frame_error = ter_q;

endmodule
`default_nettype wire

// ==== sim/pmr_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module pmr_asserts #(
  parameter int WU_CYC = pmr_pkg::WU_SETTLE_CYC
) (
  input wire logic                       clock,
  input wire logic                       rstn,
  input wire logic                       logic_ok,
  input wire logic                       batt_ok,
  input wire logic                       cs_n,
  input wire logic                       sclk,
  input wire logic                       mosi,
  input wire logic                       so_oe,
  input wire logic [pmr_pkg::CHAN_N-1:0] chan_out,
  input wire logic                       sleep_mode,
  input wire logic                       uv_reset,
  input wire logic                       frame_error
);
  import pmr_pkg::*;

  default clocking dc @(posedge clock);
  endclocking
  default disable iff (!rstn);
  // ----------------------------------------------------------------
  // Frame capture
  // ----------------------------------------------------------------
  logic       cs_q;
  logic       sclk_q;
  logic [7:0] byte_q;
  int         wait_q;
  wire        cs_rise = cs_n & ~cs_q;
  wire        is_cmd  = cs_rise && (byte_q[7:6] == OP_CMD) && logic_ok && !uv_reset;
  wire        wake_go = is_cmd && byte_q[0] && (byte_q[2:1] == 2'h0) && sleep_mode;
  wire        stby_go = is_cmd && byte_q[1] && !byte_q[2] && !sleep_mode;
  wire        rst_go  = is_cmd && byte_q[2];
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cs_q   <= 1'b1;
      sclk_q <= 1'b0;
      byte_q <= 8'h00;
      wait_q <= 0;
    end else begin
      cs_q   <= cs_n;
      sclk_q <= sclk;
      if (sclk && !sclk_q && !cs_n) begin
        byte_q <= {byte_q[6:0], mosi};
      end
      // Two cycles of slack, since the host may start its count at the edge before we see it.
      if (cs_rise && (byte_q[7:6] == OP_CMD) && byte_q[0]) begin
        wait_q <= WU_CYC - 2;
      end else if (wait_q != 0) begin
        wait_q <= wait_q - 1;
      end
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_uv_chan; uv_reset [*3] |-> chan_out == '0; endproperty
  a_uv_chan: assert property (p_uv_chan) else $error("channels on in reset");
  property p_uv_flag; uv_reset [*3] |-> sleep_mode && frame_error; endproperty
  a_uv_flag: assert property (p_uv_flag) else $error("reset state wrong");
  property p_batt_low; !batt_ok [*3] |-> uv_reset; endproperty
  a_batt_low: assert property (p_batt_low) else $error("no undervoltage reset");
  property p_release; $fell(uv_reset) |-> $past(logic_ok, 2) && $past(batt_ok, 2); endproperty
  a_release: assert property (p_release) else $error("early reset release");
  property p_sleep_chan; sleep_mode [*2] |-> chan_out == '0; endproperty
  a_sleep_chan: assert property (p_sleep_chan) else $error("channels on in sleep");
  property p_logic_low; !logic_ok [*4] |-> !so_oe; endproperty
  a_logic_low: assert property (p_logic_low) else $error("output driven unpowered");
  property p_settle; (cs_q && !cs_n) |-> wait_q == 0; endproperty
  a_settle: assert property (p_settle) else $error("frame inside settle time");
  property p_wake; wake_go |-> ##[1:8] !sleep_mode; endproperty
  a_wake: assert property (p_wake) else $error("wake not taken");
  property p_stby; stby_go |-> ##[1:8] sleep_mode; endproperty
  a_stby: assert property (p_stby) else $error("standby not taken");
  property p_srst; rst_go |-> ##[1:8] (chan_out == '0) && sleep_mode && frame_error; endproperty
  a_srst: assert property (p_srst) else $error("soft reset not taken");
  c_wake: cover property (wake_go);
  c_stby: cover property (stby_go);
  c_srst: cover property (rst_go);
  c_uv: cover property ($rose(uv_reset));
endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pmr_pkg::*;
  localparam int WU = 50;
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic        logic_ok = 1'b1;
  logic        batt_ok = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [3:0]  sel = 4'hF;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] rd;
  logic        ack;
  logic        irq;
  logic [5:0]  chan_out;
  logic        sleep_mode;
  logic        uv_reset;
  logic        frame_error;
  int          n_mismatch = 0;
  int          total_checks = 0;
  pmr_link_if  link_inst ();
  always #4 clock = ~clock;
  pmr_dev #(.WU_CYC(WU)) pmr_dev_inst (.clock(clock), .rstn(rstn), .logic_ok(logic_ok), .batt_ok(batt_ok),
    .link(link_inst), .chan_out(chan_out), .sleep_mode(sleep_mode), .uv_reset(uv_reset), .frame_error(frame_error));
  pmr_host #(.WU_CYC(WU)) pmr_host_inst (.clock(clock), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq(irq), .link(link_inst));
  pmr_asserts #(.WU_CYC(WU)) pmr_asserts_inst (.clock(clock), .rstn(rstn), .logic_ok(logic_ok), .batt_ok(batt_ok),
    .cs_n(link_inst.cs_n), .sclk(link_inst.sclk), .mosi(link_inst.mosi), .so_oe(link_inst.so_oe),
    .chan_out(chan_out), .sleep_mode(sleep_mode), .uv_reset(uv_reset), .frame_error(frame_error));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic timeout(input string what);
    n_mismatch++;
    $display("ERROR %s expected done seen timeout", what);
    tally_and_finish();
  endtask
  // One classic cycle; read data is taken at the edge that samples ack.
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    @(posedge clock);
    while (ack !== 1'b1 && k < 100) begin
      @(posedge clock);
      k++;
    end
    if (k >= 100) timeout("wb ack");
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clock);
  endtask
  task automatic idle_wait(input logic [31:0] m);
    int k;
    k = 0;
    wb(1'b0, WB_STAT, 32'h0);
    while ((rd & m) !== 32'h0 && k < 200) begin
      wb(1'b0, WB_STAT, 32'h0);
      k++;
    end
    if (k >= 200) timeout("status idle");
  endtask
  // Leaves the status word, with the byte the device answered, in rd.
  task automatic send(input logic [7:0] b);
    int k;
    k = 0;
    idle_wait(32'h3);
    wb(1'b1, WB_TX, {24'h0, b});
    while (irq !== 1'b1 && k < 400) begin
      @(posedge clock);
      k++;
    end
    if (k >= 400) timeout("frame done");
    wb(1'b1, WB_IRQ_STAT, 32'h1);
    check("irq cleared", 32'h0, 32'(irq));
    idle_wait(32'h1);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    check("sleep", 32'h1, 32'(sleep_mode));
    check("flag", 32'h1, 32'(frame_error));
    check("chan", 32'h0, 32'(chan_out));
    check("uv", 32'h0, 32'(uv_reset));
    wb(1'b0, WB_IRQ_MASK, 32'h0);
    check("mask", 32'h0, rd);
    wb(1'b1, 4'h2, 32'hF);
    wb(1'b0, 4'h2, 32'h0);
    check("unmapped", 32'h0, rd);
    sel <= 4'h0;
    wb(1'b1, WB_IRQ_MASK, 32'h3);
    sel <= 4'hF;
    wb(1'b0, WB_IRQ_MASK, 32'h0);
    check("mask without lane", 32'h0, rd);
    wb(1'b1, WB_IRQ_MASK, 32'h1);
    $display("test reset done");
  endtask
  task automatic t_wake();
    send(8'hC1);
    check("rsp", 32'hC0, 32'(rd[15:8]));
    check("settle", 32'h1, 32'(rd[1]));
    check("sleep", 32'h0, 32'(sleep_mode));
    wb(1'b1, WB_TX, 32'h81);
    wb(1'b0, WB_STAT, 32'h0);
    check("refused", 32'h0, 32'(rd[0]));
    wb(1'b0, WB_TX, 32'h0);
    check("tx kept", 32'hC1, rd);
    wb(1'b0, WB_IRQ_STAT, 32'h0);
    check("ter irq", 32'h1, 32'(rd[1]));
    wb(1'b1, WB_IRQ_MASK, 32'h2);
    check("ter irq line", 32'h1, 32'(irq));
    wb(1'b1, WB_IRQ_STAT, 32'h2);
    wb(1'b0, WB_IRQ_STAT, 32'h0);
    check("irq stat", 32'h0, rd);
    check("irq line", 32'h0, 32'(irq));
    wb(1'b1, WB_IRQ_MASK, 32'h1);
    send(8'hAA);
    check("chan", 32'h2A, 32'(chan_out));
    check("rsp", 32'h00, 32'(rd[15:8]));
    $display("test wake done");
  endtask
  task automatic t_standby();
    send(8'hC2);
    check("sleep", 32'h1, 32'(sleep_mode));
    check("chan", 32'h0, 32'(chan_out));
    send(8'hAA);
    check("chan", 32'h0, 32'(chan_out));
    check("rsp", 32'h40, 32'(rd[15:8]));
    $display("test standby done");
  endtask
  task automatic t_soft();
    send(8'hC1);
    send(8'hBF);
    check("chan", 32'h3F, 32'(chan_out));
    send(8'hC4);
    check("chan", 32'h0, 32'(chan_out));
    check("sleep", 32'h1, 32'(sleep_mode));
    check("flag", 32'h1, 32'(frame_error));
    $display("test soft reset done");
  endtask
  task automatic t_uv();
    send(8'hC1);
    send(8'hAA);
    batt_ok <= 1'b0;
    repeat (6) @(posedge clock);
    check("uv", 32'h1, 32'(uv_reset));
    check("chan", 32'h0, 32'(chan_out));
    check("flag", 32'h1, 32'(frame_error));
    send(8'h00);
    check("rsp", 32'hC0, 32'(rd[15:8]));
    logic_ok <= 1'b0;
    batt_ok  <= 1'b1;
    repeat (6) @(posedge clock);
    check("uv", 32'h1, 32'(uv_reset));
    send(8'h00);
    check("rsp", 32'hFF, 32'(rd[15:8]));
    logic_ok <= 1'b1;
    repeat (6) @(posedge clock);
    check("uv", 32'h0, 32'(uv_reset));
    $display("test undervoltage done");
  endtask
  initial begin
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    repeat (4) @(posedge clock);
    t_reset();
    t_wake();
    t_standby();
    t_soft();
    t_uv();
    tally_and_finish();
  end
endmodule
`default_nettype wire
